// File: shared/gpio_regs_pkg.sv
// Register map, field widths and reset values of the three-port GPIO block
package gpio_regs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIRST_PULLUP = 8'h00;
  localparam logic [7:0] IDX_ADC_DATA = 8'h01;
  localparam logic [7:0] IDX_SEVEN_DATA = 8'h02;
  localparam logic [7:0] IDX_FIRST_DIR = 8'h03;
  localparam logic [7:0] IDX_ADC_DIR = 8'h04;
  localparam logic [7:0] IDX_SEVEN_DIR = 8'h05;
  localparam logic [7:0] IDX_SEVEN_PULLUP = 8'h06;
  localparam int unsigned FIRST_W = 8;
  localparam int unsigned ADC_W = 8;
  localparam int unsigned SEVEN_W = 7;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [2:0] ADC_CH_W = 3'h3;
endpackage

// File: hdl/gpio_pin_cell.sv
// Per-port pin control: output enable, pull-up gating, read-back mux
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] dir_i,
  input wire logic [WIDTH-1:0] latch_i,
  input wire logic [WIDTH-1:0] pullup_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] analog_sel_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic [WIDTH-1:0] pullup_on_o,
  output logic [WIDTH-1:0] read_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // Analog selection overrides the digital driver
      assign pin_oe_o[g] = dir_i[g] & ~analog_sel_i[g];
      assign pin_o[g] = latch_i[g];
      // Pull-up only on a digital input with its enable set
      assign pullup_on_o[g] = pullup_i[g] & ~dir_i[g] & ~analog_sel_i[g];
      // Direction picks latch or pin even for analog pins
      assign read_o[g] = dir_i[g] ? latch_i[g] : pin_i[g];
    end
  endgenerate
endmodule
`default_nettype wire

// File: hdl/three_port_gpio.sv
// Three-port GPIO with pull-ups and ADC-shared port, Wishbone slave
// Functional notes
// - A pull-up acts only while its pin is an input and enabled.
// - The first port has eight pull-up enables, 1 connects, 0 not.
// - Reset clears all first port direction bits.
// - The ADC-shared port has eight data latches reset leaves alone.
// - ADC port direction 1 drives the pin; reset clears all to 0.
// - ADC port data reads latch for outputs and pin for inputs; an analog-selected pin with direction 1 still reads its latch.
// - Data latch writes always land, whatever the direction.
// - A pin selected as analog channel is forced to analog input.
// - Unselected ADC port pins act as ordinary digital pins.
// - The third port has seven data latches reset leaves alone.
// - Seven-bit port direction 1 is output; reset clears all.
// - Seven-bit port data reads latch for outputs, pin otherwise.
// - The seven-bit port has one pull-up enable per pin.
// - Seven-bit pin mode follows the pull-up and direction table.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module three_port_gpio #(
  parameter int unsigned FIRST_W = gpio_regs_pkg::FIRST_W,
  parameter int unsigned ADC_W = gpio_regs_pkg::ADC_W,
  parameter int unsigned SEVEN_W = gpio_regs_pkg::SEVEN_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gpio_regs_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [gpio_regs_pkg::DATA_W-1:0] wb_dat_i,
  output logic [gpio_regs_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic adc_enable_i,
  input wire logic [2:0] adc_channel_i,
  output logic [FIRST_W-1:0] first_pullup_on_o,
  input wire logic [ADC_W-1:0] adc_pin_i,
  output logic [ADC_W-1:0] adc_pin_o,
  output logic [ADC_W-1:0] adc_pin_oe_o,
  output logic [ADC_W-1:0] analog_channel_inputs_o,
  input wire logic [SEVEN_W-1:0] seven_pin_i,
  output logic [SEVEN_W-1:0] seven_pin_o,
  output logic [SEVEN_W-1:0] seven_pin_oe_o,
  output logic [SEVEN_W-1:0] seven_pullup_on_o
);
  logic [FIRST_W-1:0] first_pullup_reg, first_pullup_next;
  logic [FIRST_W-1:0] first_dir_reg, first_dir_next;
  logic [ADC_W-1:0] adc_data_reg, adc_data_next;
  logic [ADC_W-1:0] adc_dir_reg, adc_dir_next;
  logic [SEVEN_W-1:0] seven_data_reg, seven_data_next;
  logic [SEVEN_W-1:0] seven_dir_reg, seven_dir_next;
  logic [SEVEN_W-1:0] seven_pullup_reg, seven_pullup_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [gpio_regs_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic [ADC_W-1:0] adc_sel;
  logic [ADC_W-1:0] adc_read;
  logic [SEVEN_W-1:0] seven_read;
  logic [7:0] idx;
  logic req;
  logic wr_lane0;

  // Only one analog channel is selected at a time
  always_comb
  begin
    adc_sel = '0;
    if (adc_enable_i)
    begin
      adc_sel[adc_channel_i] = 1'b1;
    end
  end
  assign analog_channel_inputs_o = adc_sel;

  // ADC-shared port: no pull-up, so its pull-up leg is tied off
  gpio_pin_cell #(
    .WIDTH(ADC_W)
  ) u_adc_cell (
    .dir_i(adc_dir_reg),
    .latch_i(adc_data_reg),
    .pullup_i({ADC_W{1'b0}}),
    .pin_i(adc_pin_i),
    .analog_sel_i(adc_sel),
    .pin_o(adc_pin_o),
    .pin_oe_o(adc_pin_oe_o),
    .pullup_on_o(),
    .read_o(adc_read)
  );

  gpio_pin_cell #(
    .WIDTH(SEVEN_W)
  ) u_seven_cell (
    .dir_i(seven_dir_reg),
    .latch_i(seven_data_reg),
    .pullup_i(seven_pullup_reg),
    .pin_i(seven_pin_i),
    .analog_sel_i({SEVEN_W{1'b0}}),
    .pin_o(seven_pin_o),
    .pin_oe_o(seven_pin_oe_o),
    .pullup_on_o(seven_pullup_on_o),
    .read_o(seven_read)
  );

  // First port pull-ups gated by its own direction bits
  assign first_pullup_on_o = first_pullup_reg & ~first_dir_reg;

  // Word-aligned decode; byte offset bits are ignored
  assign idx = {2'b00, wb_adr_i[gpio_regs_pkg::ADDR_W-1:2]};
  // A request is answered once; ack drops for a cycle before the next
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

  always_comb
  begin
    first_pullup_next = first_pullup_reg;
    first_dir_next = first_dir_reg;
    adc_data_next = adc_data_reg;
    adc_dir_next = adc_dir_reg;
    seven_data_next = seven_data_reg;
    seven_dir_next = seven_dir_reg;
    seven_pullup_next = seven_pullup_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    rdata_next = rdata_reg;
    if (req)
    begin
      ack_next = 1'b1;
      rdata_next = '0;
      if (idx == gpio_regs_pkg::IDX_FIRST_PULLUP)
      begin
        rdata_next[FIRST_W-1:0] = first_pullup_reg;
        if (wr_lane0)
          first_pullup_next = wb_dat_i[FIRST_W-1:0];
      end
      else if (idx == gpio_regs_pkg::IDX_ADC_DATA)
      begin
        rdata_next[ADC_W-1:0] = adc_read;
        if (wr_lane0)
          adc_data_next = wb_dat_i[ADC_W-1:0];
      end
      else if (idx == gpio_regs_pkg::IDX_SEVEN_DATA)
      begin
        // Upper bits stay zero, bit 7 is never stored
        rdata_next[SEVEN_W-1:0] = seven_read;
        if (wr_lane0)
          seven_data_next = wb_dat_i[SEVEN_W-1:0];
      end
      else if (idx == gpio_regs_pkg::IDX_FIRST_DIR)
      begin
        rdata_next[FIRST_W-1:0] = first_dir_reg;
        if (wr_lane0)
          first_dir_next = wb_dat_i[FIRST_W-1:0];
      end
      else if (idx == gpio_regs_pkg::IDX_ADC_DIR)
      begin
        rdata_next[ADC_W-1:0] = adc_dir_reg;
        if (wr_lane0)
          adc_dir_next = wb_dat_i[ADC_W-1:0];
      end
      else if (idx == gpio_regs_pkg::IDX_SEVEN_DIR)
      begin
        rdata_next[SEVEN_W-1:0] = seven_dir_reg;
        if (wr_lane0)
          seven_dir_next = wb_dat_i[SEVEN_W-1:0];
      end
      else if (idx == gpio_regs_pkg::IDX_SEVEN_PULLUP)
      begin
        rdata_next[SEVEN_W-1:0] = seven_pullup_reg;
        if (wr_lane0)
          seven_pullup_next = wb_dat_i[SEVEN_W-1:0];
      end
      else
      begin
        // Unmapped word: error instead of ack, nothing stored
        ack_next = 1'b0;
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    // Data latches keep their contents through reset
    adc_data_reg <= adc_data_next;
    seven_data_reg <= seven_data_next;
    if (!rst_b_i)
    begin
      first_dir_reg <= gpio_regs_pkg::DIR_RESET[FIRST_W-1:0];
      adc_dir_reg <= gpio_regs_pkg::DIR_RESET[ADC_W-1:0];
      seven_dir_reg <= gpio_regs_pkg::DIR_RESET[SEVEN_W-1:0];
      first_pullup_reg <= gpio_regs_pkg::PULLUP_RESET[FIRST_W-1:0];
      seven_pullup_reg <= gpio_regs_pkg::PULLUP_RESET[SEVEN_W-1:0];
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      first_dir_reg <= first_dir_next;
      adc_dir_reg <= adc_dir_next;
      seven_dir_reg <= seven_dir_next;
      first_pullup_reg <= first_pullup_next;
      seven_pullup_reg <= seven_pullup_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;
endmodule
`default_nettype wire

// File: dv/three_port_gpio_monitor.sv
// Port-level assertions for the three-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module three_port_gpio_monitor (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic adc_enable_i,
  input wire logic [2:0] adc_channel_i,
  input wire logic [7:0] adc_pin_oe_o,
  input wire logic [7:0] analog_channel_inputs_o,
  input wire logic [6:0] seven_pin_o,
  input wire logic [6:0] seven_pin_oe_o,
  input wire logic [6:0] seven_pullup_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    wb_ack_o != wb_err_o;
  endsequence
  property p_answer; s_taken |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_pulse; s_answer |=> !wb_ack_o && !wb_err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_rst; $rose(rst_b_i) |-> (seven_pin_oe_o | adc_pin_oe_o) == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("oe after reset");
  property p_pu_off; (seven_pullup_on_o & seven_pin_oe_o) == '0; endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up on output");
  property p_an_oe; (analog_channel_inputs_o & adc_pin_oe_o) == '0; endproperty
  a_an_oe: assert property (p_an_oe) else $error("analog pin driven");
  property p_sel; analog_channel_inputs_o ==
    ({7'h00, adc_enable_i} << adc_channel_i); endproperty
  a_sel: assert property (p_sel) else $error("bad channel");
  property p_latch; $changed(seven_pin_o) |-> wb_ack_o; endproperty
  a_latch: assert property (p_latch) else $error("latch moved");
  property p_dir; $changed(seven_pin_oe_o) && $past(rst_b_i) |-> wb_ack_o;
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
endmodule
bind three_port_gpio three_port_gpio_monitor i_mon (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .adc_enable_i(adc_enable_i),
  .adc_channel_i(adc_channel_i), .adc_pin_oe_o(adc_pin_oe_o),
  .analog_channel_inputs_o(analog_channel_inputs_o),
  .seven_pin_o(seven_pin_o), .seven_pin_oe_o(seven_pin_oe_o),
  .seven_pullup_on_o(seven_pullup_on_o));
`default_nettype wire

// File: dv/gpio_pin_model.sv
// Pad model: the level each pin shows from outside the block
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] pullup_i,
  input wire logic [W-1:0] drive_en_i,
  input wire logic [W-1:0] drive_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] float_reg = '0;
  // A floating pad has no level; toggle so no test can rely on one
  always @(posedge clk_i) float_reg <= ~float_reg;
  always_comb
    for (int i = 0; i < W; i++)
      level_o[i] = oe_i[i] ? out_i[i] : drive_en_i[i] ? drive_i[i]
        : pullup_i[i] ? 1'b1 : float_reg[i];
endmodule
`default_nettype wire

// File: dv/three_port_gpio_tb_top.sv
// Register-level tests of the three-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module three_port_gpio_tb_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, e, adc_en = 1'b0;
  logic [7:0] adr = 8'h00, first_pu, adc_in, adc_out, adc_oe, analog;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [2:0] adc_ch = 3'h0;
  logic [3:0] sel = 4'h1;
  logic [7:0] adc_drv = 8'h3c;
  logic [6:0] sev_in, sev_out, sev_oe, sev_pu, sev_drv = 7'h7f;
  int n_errors = 0, n_tests = 0;
  always #10 clk_i = ~clk_i;
  three_port_gpio i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .adc_enable_i(adc_en), .adc_channel_i(adc_ch),
    .first_pullup_on_o(first_pu), .adc_pin_i(adc_in), .adc_pin_o(adc_out),
    .adc_pin_oe_o(adc_oe), .analog_channel_inputs_o(analog),
    .seven_pin_i(sev_in), .seven_pin_o(sev_out), .seven_pin_oe_o(sev_oe),
    .seven_pullup_on_o(sev_pu));
  // No pull-ups on the converter-shared port
  gpio_pin_model #(.W(8)) i_adc_pads (.clk_i(clk_i), .oe_i(adc_oe),
    .out_i(adc_out), .pullup_i(8'h00), .drive_en_i(8'hff),
    .drive_i(adc_drv), .level_o(adc_in));
  gpio_pin_model #(.W(7)) i_sev_pads (.clk_i(clk_i), .oe_i(sev_oe),
    .out_i(sev_out), .pullup_i(sev_pu), .drive_en_i(sev_drv),
    .drive_i(7'h55), .level_o(sev_in));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] idx, input logic w,
    input logic [7:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx[5:0], 2'b00};
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++)
      if (i != 1 && i != 2)
      begin
        xfer(8'(i), 1'b0, 8'h00);
        chk("reset value", q, 32'h0);
      end
    xfer(gpio_regs_pkg::IDX_SEVEN_DATA, 1'b1, 8'hff);
    xfer(gpio_regs_pkg::IDX_SEVEN_DATA, 1'b0, 8'h00);
    chk("seven input read", q, 32'h55);
    xfer(gpio_regs_pkg::IDX_SEVEN_PULLUP, 1'b1, 8'hff);
    xfer(gpio_regs_pkg::IDX_SEVEN_DIR, 1'b1, 8'hff);
    xfer(gpio_regs_pkg::IDX_SEVEN_DIR, 1'b0, 8'h00);
    chk("seven dir bit 7", q, 32'h7f);
    chk("seven drive", {sev_oe, sev_out, sev_pu}, 32'h1fff80);
    xfer(gpio_regs_pkg::IDX_SEVEN_DIR, 1'b1, 8'h0f);
    chk("seven pull-ups", sev_pu, 32'h70);
    xfer(gpio_regs_pkg::IDX_SEVEN_DATA, 1'b0, 8'h00);
    chk("seven mixed read", q, 32'h5f);
    sev_drv <= 7'h0f;
    xfer(gpio_regs_pkg::IDX_SEVEN_DATA, 1'b0, 8'h00);
    chk("seven pulled read", q, 32'h7f);
    xfer(gpio_regs_pkg::IDX_FIRST_PULLUP, 1'b1, 8'ha5);
    xfer(gpio_regs_pkg::IDX_FIRST_DIR, 1'b1, 8'h0f);
    chk("first pull-ups", first_pu, 32'ha0);
    // A write without lane 0 is acknowledged but must store nothing
    sel <= 4'he;
    xfer(gpio_regs_pkg::IDX_FIRST_PULLUP, 1'b1, 8'h00);
    sel <= 4'h1;
    xfer(gpio_regs_pkg::IDX_FIRST_PULLUP, 1'b0, 8'h00);
    chk("lane 0 off write", q, 32'ha5);
    xfer(gpio_regs_pkg::IDX_ADC_DATA, 1'b1, 8'h96);
    xfer(gpio_regs_pkg::IDX_ADC_DIR, 1'b1, 8'hf0);
    xfer(gpio_regs_pkg::IDX_ADC_DATA, 1'b0, 8'h00);
    chk("adc mixed read", q, 32'h9c);
    adc_drv <= 8'hc3;
    xfer(gpio_regs_pkg::IDX_ADC_DATA, 1'b0, 8'h00);
    chk("adc pin follow", q, 32'h93);
    for (int c = 0; c < 8; c++)
    begin
      adc_en <= 1'b1;
      adc_ch <= 3'(c);
      @(posedge clk_i);
      chk("analog pick", analog, 32'(8'h01 << c));
      chk("adc oe", adc_oe, 32'(8'hf0 & ~(8'h01 << c)));
    end
    adc_en <= 1'b0;
    xfer(8'h07, 1'b0, 8'h00);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", q, 32'h0);
    rst_b_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk("adc latch kept", adc_out, 32'h96);
    chk("seven latch kept", sev_out, 32'h7f);
    chk("oe cleared", {adc_oe, sev_oe}, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
